// [logic/asr_defs.svh]
// asr_defs.svh: addresses, field positions and reset values of the
// alert cause and pin routing registers.
// assumes: included by bare name from the package and design files.
`ifndef ASR_DEFS_SVH
`define ASR_DEFS_SVH

// register addresses on the device's register port
`define ASR_ADDR_W 8
`define ASR_ADDR_CAUSE 8'h26
`define ASR_ADDR_ROUTE 8'h27

// register width and field positions
`define ASR_REG_W 24
`define ASR_OC_HI 23
`define ASR_OC_LO 20
`define ASR_UC_HI 19
`define ASR_UC_LO 16
`define ASR_OV_HI 15
`define ASR_OV_LO 12
`define ASR_UV_HI 11
`define ASR_UV_LO 8
`define ASR_OP_HI 7
`define ASR_OP_LO 4
`define ASR_ACC_FULL_BIT 3
`define ASR_ACCUMULATION_COUNT_FLAG_BIT 2
`define ASR_CC_ROUTE_BIT 1

// implemented-bit masks and reset values
`define ASR_CAUSE_MASK 24'hff_fffc
`define ASR_ROUTE_MASK 24'hff_fffe
`define ASR_ROUTE_RESET 24'h00_0000
`define ASR_CAUSE_RESET 24'h00_0000
`define ASR_ZERO_WORD 24'h00_0000

`endif

// [logic/asr_pkg.sv]
// asr_pkg.sv: types shared by the alert cause and routing block.
// assumes: asr_defs.svh is on the include path.
`include "asr_defs.svh"

package asr_pkg;

  // one register access request, from the serial port logic
  typedef struct packed {
    logic [`ASR_ADDR_W-1:0] addr;
    logic wr;
    logic rd;
    logic [`ASR_REG_W-1:0] wdata;
  } asr_reg_req_t;

  // registered read answer
  typedef struct packed {
    logic [`ASR_REG_W-1:0] rdata;
    logic valid;
  } asr_reg_rsp_t;

  // comparator and accumulator conditions, channel 1 at the left
  typedef struct packed {
    logic [1:4] overcurrent;
    logic [1:4] undercurrent;
    logic [1:4] overvoltage;
    logic [1:4] undervoltage;
    logic [1:4] overpower;
    logic accumulator_full_flag;
    logic accumulation_count_flag;
  } asr_cond_t;

  // read-then-clear tracking states
  typedef enum logic [1:0] {
    ASR_ST_IDLE = 2'b01,
    ASR_ST_ARMED = 2'b10
  } asr_clr_state_t;

endpackage : asr_pkg

// [logic/asr_cause_flags.sv]
// asr_cause_flags.sv: sticky alert cause flags, updated at each
// conversion completion and cleared after a read plus one completion.
// assumes: conv_done and cause_read are one-cycle pulses on clock.
`include "asr_defs.svh"

module asr_cause_flags (
  input wire logic clock,
  input wire logic reset,
  input wire logic conv_done,
  input wire logic cause_read,
  input wire logic [`ASR_REG_W-1:0] cond,
  output logic [`ASR_REG_W-1:0] flags
);
  import asr_pkg::*;

  asr_clr_state_t state_r;
  asr_clr_state_t state_nxt;
  logic clear_now;

  // a read arms the clear; the next completion performs it
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ASR_ST_IDLE: begin
        if (cause_read) begin
          state_nxt = ASR_ST_ARMED;
        end
      end
      ASR_ST_ARMED: begin
        if (conv_done && !cause_read) begin
          state_nxt = ASR_ST_IDLE;
        end
      end
      default: begin
        state_nxt = ASR_ST_IDLE;
      end
    endcase
  end

  assign clear_now = conv_done && (state_r == ASR_ST_ARMED);

  // state register
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state_r <= ASR_ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // one flag per bit; a present condition keeps or sets it
  genvar i;
  generate
    for (i = 0; i < `ASR_REG_W; i = i + 1) begin : g_flag
      logic flag_r;
      logic flag_nxt;
      assign flag_nxt = conv_done ?
        ((flag_r && !clear_now) || cond[i]) : flag_r;
      always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
          flag_r <= 1'b0;
        end else begin
          flag_r <= flag_nxt;
        end
      end
      assign flags[i] = flag_r;
    end
  endgenerate

endmodule : asr_cause_flags

// [logic/asr_alert_top.sv]
// asr_alert_top.sv: alert cause register, slow/alert pin routing
// register and the drive of the shared slow/alert pin.
// assumes: one 40 MHz clock; the serial port logic presents one
// register access at a time as a request struct; comparators, the
// alert enable register and the pin function setting are outside.
// the pin level here is active high; pad polarity is set outside.
// a cause read in the same cycle as a completion arms the clear for
// the following completion, so no trip is lost between read and clear.
// reads answer one cycle after the read strobe; writes have no answer.
`include "asr_defs.svh"

module asr_alert_top (
  input wire logic clock,
  input wire logic reset,
  input asr_pkg::asr_reg_req_t reg_req,
  output asr_pkg::asr_reg_rsp_t reg_rsp,
  input asr_pkg::asr_cond_t cond,
  input wire logic conv_done,
  input wire logic [`ASR_REG_W-1:0] alert_enable,
  input wire logic pin_is_alert,
  output logic slow_or_alert_pin
);
  import asr_pkg::*;

  // condition vector in register bit order
  logic [`ASR_REG_W-1:0] cond_vec;
  // register views and next values
  logic [`ASR_REG_W-1:0] cause_flags;
  logic [`ASR_REG_W-1:0] cause_view;
  logic [`ASR_REG_W-1:0] route_r;
  logic [`ASR_REG_W-1:0] route_nxt;
  logic [`ASR_REG_W-1:0] route_wdata;
  logic [`ASR_REG_W-1:0] active_vec;
  logic [`ASR_REG_W-1:0] read_mux;
  // request fields and decode strobes
  logic [`ASR_ADDR_W-1:0] req_addr;
  logic req_wr;
  logic req_rd;
  logic [`ASR_REG_W-1:0] req_wdata;
  logic hit_cause;
  logic hit_route;
  logic cause_read;
  logic route_write;
  // tripped sources per alert class
  logic [1:4] oc_tripped;
  logic [1:4] uc_tripped;
  logic [1:4] ov_tripped;
  logic [1:4] uv_tripped;
  logic [1:4] op_tripped;
  logic acc_full_tripped;
  logic accumulation_count_flag_tripped;
  // qualified sources and per-class hits
  logic [`ASR_REG_W-1:`ASR_CC_ROUTE_BIT] qual_vec;
  logic oc_hit;
  logic uc_hit;
  logic ov_hit;
  logic uv_hit;
  logic op_hit;
  logic acc_full_hit;
  logic accumulation_count_flag_hit;
  logic cc_hit;
  logic any_hit;
  // event flag, pin and answer next values
  logic cc_flag_r;
  logic cc_flag_nxt;
  logic cc_set;
  logic cc_clr;
  logic pin_nxt;
  asr_reg_rsp_t rsp_nxt;

  // pack the comparator conditions into the cause layout
  assign cond_vec[`ASR_OC_HI:`ASR_OC_LO] = cond.overcurrent;
  assign cond_vec[`ASR_UC_HI:`ASR_UC_LO] = cond.undercurrent;
  assign cond_vec[`ASR_OV_HI:`ASR_OV_LO] = cond.overvoltage;
  assign cond_vec[`ASR_UV_HI:`ASR_UV_LO] = cond.undervoltage;
  assign cond_vec[`ASR_OP_HI:`ASR_OP_LO] = cond.overpower;
  assign cond_vec[`ASR_ACC_FULL_BIT] = cond.accumulator_full_flag;
  assign cond_vec[`ASR_ACCUMULATION_COUNT_FLAG_BIT] =
    cond.accumulation_count_flag;
  assign cond_vec[`ASR_CC_ROUTE_BIT:0] = 2'b00;

  // sticky flags with read-then-completion clearing
  asr_cause_flags u_flags (
    .clock(clock),
    .reset(reset),
    .conv_done(conv_done),
    .cause_read(cause_read),
    .cond(cond_vec),
    .flags(cause_flags)
  );

  // unimplemented cause bits are forced to zero on read
  assign cause_view = cause_flags & `ASR_CAUSE_MASK;

  // request fields taken apart
  assign req_addr = reg_req.addr;
  assign req_wr = reg_req.wr;
  assign req_rd = reg_req.rd;
  assign req_wdata = reg_req.wdata;

  // address decode; a write to the cause register has no effect
  assign hit_cause = (req_addr == `ASR_ADDR_CAUSE);
  assign hit_route = (req_addr == `ASR_ADDR_ROUTE);
  assign cause_read = req_rd && hit_cause;
  assign route_write = req_wr && hit_route;

  // routing register: bit 0 is not implemented and stays zero
  assign route_wdata = req_wdata & `ASR_ROUTE_MASK;
  assign route_nxt = route_write ? route_wdata : route_r;

  // read data selection; unmapped addresses answer zero
  assign read_mux = hit_cause ? cause_view :
                    hit_route ? route_r : `ASR_ZERO_WORD;

  // answer data holds the last read value between reads
  assign rsp_nxt.rdata = req_rd ? read_mux : reg_rsp.rdata;
  assign rsp_nxt.valid = req_rd;

  // conversion-complete event: set by every completion, cleared by a
  // cause read; when both fall in one cycle the set wins
  assign cc_set = conv_done;
  assign cc_clr = cause_read;
  assign cc_flag_nxt = cc_set || (cc_flag_r && !cc_clr);

  // tripped sources per class, taken from the readable cause view
  // (the cause view already has bits 1 and 0 forced to zero)
  assign oc_tripped = cause_view[`ASR_OC_HI:`ASR_OC_LO];
  assign uc_tripped = cause_view[`ASR_UC_HI:`ASR_UC_LO];
  assign ov_tripped = cause_view[`ASR_OV_HI:`ASR_OV_LO];
  assign uv_tripped = cause_view[`ASR_UV_HI:`ASR_UV_LO];
  assign op_tripped = cause_view[`ASR_OP_HI:`ASR_OP_LO];
  assign acc_full_tripped = cause_view[`ASR_ACC_FULL_BIT];
  assign accumulation_count_flag_tripped = cause_view[`ASR_ACCUMULATION_COUNT_FLAG_BIT];

  // sources in routing layout; the completion event sits in bit 1
  assign active_vec = {oc_tripped, uc_tripped, ov_tripped, uv_tripped,
                       op_tripped, acc_full_tripped, accumulation_count_flag_tripped,
                       cc_flag_r, 1'b0};

  // a source counts only when tripped, routed and enabled; bit 0 is
  // not implemented in either register, so the loop starts at bit 1
  genvar b;
  generate
    for (b = `ASR_CC_ROUTE_BIT; b < `ASR_REG_W; b = b + 1) begin : g_qual
      assign qual_vec[b] = active_vec[b] && route_r[b] &&
        alert_enable[b];
    end
  endgenerate

  // per-class hits
  assign oc_hit = |qual_vec[`ASR_OC_HI:`ASR_OC_LO];
  assign uc_hit = |qual_vec[`ASR_UC_HI:`ASR_UC_LO];
  assign ov_hit = |qual_vec[`ASR_OV_HI:`ASR_OV_LO];
  assign uv_hit = |qual_vec[`ASR_UV_HI:`ASR_UV_LO];
  assign op_hit = |qual_vec[`ASR_OP_HI:`ASR_OP_LO];
  assign acc_full_hit = qual_vec[`ASR_ACC_FULL_BIT];
  assign accumulation_count_flag_hit = qual_vec[`ASR_ACCUMULATION_COUNT_FLAG_BIT];
  assign cc_hit = qual_vec[`ASR_CC_ROUTE_BIT];

  // any qualified class requests the pin
  assign any_hit = oc_hit || uc_hit || ov_hit || uv_hit || op_hit ||
    acc_full_hit || accumulation_count_flag_hit || cc_hit;

  // pin drive: in alert function only
  assign pin_nxt = pin_is_alert && any_hit;

  // routing register, reset to zero
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      route_r <= `ASR_ROUTE_RESET;
    end else begin
      route_r <= route_nxt;
    end
  end

  // conversion-complete event flag
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      cc_flag_r <= 1'b0;
    end else begin
      cc_flag_r <= cc_flag_nxt;
    end
  end

  // registered read answer
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      reg_rsp <= '0;
    end else begin
      reg_rsp <= rsp_nxt;
    end
  end

  // registered pin level
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      slow_or_alert_pin <= 1'b0;
    end else begin
      slow_or_alert_pin <= pin_nxt;
    end
  end

endmodule : asr_alert_top

// [sim/asr_alert_monitor.sv]
// asr_alert_monitor.sv: port checks of the alert cause/routing top.
// assumes: bound to asr_alert_top, single clock domain.
`include "asr_defs.svh"
module asr_alert_monitor (
  input wire logic clock,
  input wire logic reset,
  input asr_pkg::asr_reg_req_t reg_req,
  input asr_pkg::asr_reg_rsp_t reg_rsp,
  input asr_pkg::asr_cond_t cond,
  input wire logic conv_done,
  input wire logic [`ASR_REG_W-1:0] alert_enable,
  input wire logic pin_is_alert,
  input wire logic slow_or_alert_pin
);
  timeunit 1ns;
  timeprecision 100ps;
  import asr_pkg::*;
  // read of the cause register
  wire logic rd_cause = reg_req.rd && reg_req.addr == 8'h26;
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  // register answers and unused bits
  chk_read_answer: assert property (reg_req.rd |=> reg_rsp.valid)
    else $error("read got no answer");
  chk_bit0_zero: assert property (reg_rsp.valid |-> !reg_rsp.rdata[0])
    else $error("bit 0 read as one");
  chk_cause_low: assert property ($past(rd_cause) |->
    reg_rsp.rdata[1:0] == 2'h0) else $error("cause bits 1:0 not zero");
  // pin qualification
  chk_pin_function: assert property (!pin_is_alert |=>
    !slow_or_alert_pin) else $error("pin driven outside alert function");
  chk_pin_enable: assert property (alert_enable == '0 |=>
    !slow_or_alert_pin) else $error("pin driven with nothing enabled");
  chk_pin_cause: assert property ($rose(slow_or_alert_pin) |->
    $past(pin_is_alert) && $past(alert_enable) != '0)
    else $error("pin rose without a cause");
  // flag capture and clearing
  chk_flag_sticky: assert property (conv_done ##1 !conv_done
    ##1 rd_cause |=> (reg_rsp.rdata[23:2] & $past(cond, 3)) ==
    $past(cond, 3)) else $error("present condition not flagged");
  chk_flag_clear: assert property (rd_cause ##1 !conv_done
    ##1 conv_done ##1 !conv_done ##1 rd_cause |=>
    reg_rsp.rdata[23:2] == $past(cond, 3)) else $error("flags not renewed");
endmodule : asr_alert_monitor

bind asr_alert_top asr_alert_monitor u_asr_alert_monitor (
  .clock(clock),
  .reset(reset),
  .reg_req(reg_req),
  .reg_rsp(reg_rsp),
  .cond(cond),
  .conv_done(conv_done),
  .alert_enable(alert_enable),
  .pin_is_alert(pin_is_alert),
  .slow_or_alert_pin(slow_or_alert_pin)
);

// [sim/asr_host_model.sv]
// asr_host_model.sv: host side of the register port.
// assumes: requests change at the falling edge of clock.
module asr_host_model (
  input wire logic clock,
  output asr_pkg::asr_reg_req_t reg_req,
  input asr_pkg::asr_reg_rsp_t reg_rsp
);
  timeunit 1ns;
  timeprecision 100ps;
  import asr_pkg::*;
  initial reg_req = '0;
  // one-cycle write, then address and data left inverted
  task automatic write(input logic [7:0] a, input logic [23:0] d);
    @(negedge clock);
    reg_req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(negedge clock);
    reg_req <= '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~d};
  endtask : write
  // one-cycle read; answer taken in the cycle where valid stands,
  // then the strobe drops and the address is left inverted
  task automatic read(input logic [7:0] a, output logic [23:0] d);
    @(negedge clock);
    reg_req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: '0};
    @(negedge clock);
    d = reg_rsp.valid === 1'b1 ? reg_rsp.rdata : 'x;
    reg_req <= '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: '1};
  endtask : read
endmodule : asr_host_model

// [sim/tb_alert_status_and_pin_routing.sv]
// tb_alert_status_and_pin_routing.sv: register and pin tests.
// assumes: the host model makes every register access.
module tb_alert_status_and_pin_routing;
  timeunit 1ns;
  timeprecision 100ps;
  import asr_pkg::*;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic conv_done = 1'b0;
  logic pin_is_alert = 1'b1;
  logic [23:0] alert_enable = '0;
  logic [23:0] rd_val;
  asr_cond_t cond = '0;
  asr_reg_req_t reg_req;
  asr_reg_rsp_t reg_rsp;
  logic slow_or_alert_pin;
  int err_count = 0;
  int samples_checked = 0;
  always #12.5 clock = ~clock;
  asr_alert_top u_asr_alert_top (
    .clock(clock),
    .reset(reset),
    .reg_req(reg_req),
    .reg_rsp(reg_rsp),
    .cond(cond),
    .conv_done(conv_done),
    .alert_enable(alert_enable),
    .pin_is_alert(pin_is_alert),
    .slow_or_alert_pin(slow_or_alert_pin)
  );
  asr_host_model u_asr_host_model (
    .clock(clock),
    .reg_req(reg_req),
    .reg_rsp(reg_rsp)
  );
  // compare and count
  task automatic check_value(input logic [23:0] seen, input logic [23:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
    end
  endtask : check_value
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : tally_and_finish
  // one conversion completion pulse
  task automatic convert();
    @(negedge clock);
    conv_done = 1'b1;
    @(negedge clock);
    conv_done = 1'b0;
  endtask : convert
  // pin compared one cycle after its inputs
  task automatic pin_is(input logic exp);
    @(negedge clock);
    check_value({23'h0, slow_or_alert_pin}, {23'h0, exp});
  endtask : pin_is
  initial begin
    repeat (4) @(negedge clock);
    reset = 1'b0;
    u_asr_host_model.read(8'h27, rd_val);
    check_value(rd_val, 24'h00_0000);
    u_asr_host_model.read(8'h30, rd_val);
    check_value(rd_val, 24'h00_0000);
    u_asr_host_model.write(8'h26, 24'hff_ffff);
    u_asr_host_model.read(8'h27, rd_val);
    check_value(rd_val, 24'h00_0000);
    u_asr_host_model.write(8'h27, 24'hff_ffff);
    u_asr_host_model.read(8'h27, rd_val);
    check_value(rd_val, 24'hff_fffe);
    alert_enable = 24'hff_fffd;
    // one source at a time: flag, route and pin must agree
    for (int i = 2; i < 24; i++) begin
      cond = asr_cond_t'(22'h1 << (i - 2));
      u_asr_host_model.read(8'h26, rd_val);
      convert();
      u_asr_host_model.read(8'h26, rd_val);
      check_value(rd_val, 24'h1 << i);
      u_asr_host_model.write(8'h27, ~(24'h1 << i));
      pin_is(1'b0);
      u_asr_host_model.write(8'h27, 24'h1 << i);
      pin_is(1'b1);
    end
    // flags hold until read, then clear at the next completion
    cond = '1;
    convert();
    alert_enable = '0;
    cond = '0;
    convert();
    u_asr_host_model.read(8'h26, rd_val);
    check_value(rd_val, 24'hff_fffc);
    convert();
    u_asr_host_model.read(8'h26, rd_val);
    check_value(rd_val, 24'h00_0000);
    // conversion-complete route, pin function and enable
    alert_enable = 24'hff_ffff;
    u_asr_host_model.write(8'h27, 24'h00_0002);
    convert();
    pin_is(1'b1);
    pin_is_alert = 1'b0;
    pin_is(1'b0);
    pin_is_alert = 1'b1;
    alert_enable = '0;
    pin_is(1'b0);
    alert_enable = 24'hff_ffff;
    u_asr_host_model.read(8'h26, rd_val);
    pin_is(1'b0);
    tally_and_finish();
  end
  // cut a hang short well past the expected run
  initial begin
    #100us;
    err_count++;
    tally_and_finish();
  end
endmodule : tb_alert_status_and_pin_routing
